/* hdl/pwmise_params.svh */
// Constants for the PWM iteration-suppression extension.
// Assumes a 32-bit APB slave with 12-bit byte addresses.
`ifndef PWMISE_PARAMS_SVH
`define PWMISE_PARAMS_SVH

// Geometry
`define PWMISE_CNT_W      10
`define PWMISE_ITER_W     3
`define PWMISE_NUM_CH     4
`define PWMISE_ADDR_W     12

// Low-count control register indices (byte address is index times four)
`define PWMISE_IDX_LSB0   10'h088
`define PWMISE_IDX_LSB1   10'h08A
`define PWMISE_IDX_LSB2   10'h08C
`define PWMISE_IDX_LSB3   10'h08E

// Added registers (byte addresses)
`define PWMISE_ADDR_HIGH0 12'h200
`define PWMISE_ADDR_STAT  12'h240
`define PWMISE_ADDR_MASK  12'h244
`define PWMISE_ADDR_CTRL  12'h248

// Low-count control register fields
`define PWMISE_F_CNT_HI   7
`define PWMISE_F_CNT_LO   6
`define PWMISE_F_SUP_HI   5
`define PWMISE_F_SUP_LO   4
`define PWMISE_F_IRQ_HI   2
`define PWMISE_F_IRQ_LO   1
`define PWMISE_F_SHAPE    0

// Added register fields
`define PWMISE_F_ACT_ONLY 0
`define PWMISE_F_ST_PWM   0
`define PWMISE_F_ST_ROUND 1
`define PWMISE_F_ST_ITER  8
`define PWMISE_F_ST_CNT   16

// Reset values
`define PWMISE_RST_WIDTH  10'h000
`define PWMISE_RST_CODE   2'h0
`define PWMISE_RST_EVT    2'h0
`define PWMISE_RST_DATA   32'h0000_0000

`endif

/* hdl/pwmise_pkg.sv */
// Types for the PWM iteration-suppression extension.
// Assumes pwmise_params.svh is on the include path.
`include "pwmise_params.svh"

package pwmise_pkg;

   // Whole state of the top module
   typedef struct packed {
      logic [`PWMISE_CNT_W-1:0]                         cnt;      // PWM counter
      logic [`PWMISE_ITER_W-1:0]                        iter;     // Iteration counter
      logic [`PWMISE_NUM_CH-1:0][`PWMISE_CNT_W-1:0]     width;    // Pulse widths
      logic [`PWMISE_NUM_CH-1:0][1:0]                   supp;     // Output suppression
      logic [`PWMISE_NUM_CH-1:0]                        spread;   // Output shape
      logic [1:0]                                       irqLevel; // Interrupt priority
      logic [1:0]                                       irqSupp;  // Interrupt suppression
      logic                                             actOnly;  // Active-iteration irq
      logic [1:0]                                       status;   // Sticky events
      logic [1:0]                                       mask;     // Event mask
      logic [31:0]                                      prdata;   // Read data
      logic                                             pready;   // Access done
      logic                                             pslverr;  // Unmapped access
      logic [`PWMISE_NUM_CH-1:0]                        pwmOut;   // Output pins
      logic                                             irq;      // Interrupt line
      logic [1:0]                                       irqPri;   // Priority output
   } pwmise_state_t;

endpackage

/* hdl/pwmise_iter_gate.sv */
// Decides whether the current counter iteration is active for a code.
// Assumes a free-running iteration count from the same clock domain.
`timescale 1ns/1ns
`include "pwmise_params.svh"

module pwmise_iter_gate (
   input  wire logic [1:0]                code,   // Suppression code
   input  wire logic [`PWMISE_ITER_W-1:0] iter,   // Current iteration
   output logic                           active  // Iteration passes
);

   // Iteration zero is active for every ratio
   always_comb begin
      unique case (code)
         2'h0: active = 1'b1;                 // Every iteration
         2'h1: active = (iter == 3'h0);       // One of eight
         2'h2: active = (iter[1:0] == 2'h0);  // One of four
         2'h3: active = (iter[0] == 1'b0);    // One of two
      endcase
   end

endmodule // pwmise_iter_gate

/* hdl/pwmise_channel.sv */
// Compare stage of one PWM channel: single block or spread high time.
// Assumes the shared PWM counter runs from zero to all ones.
`timescale 1ns/1ns
`include "pwmise_params.svh"

module pwmise_channel (
   input  wire logic [`PWMISE_CNT_W-1:0] cnt,     // Shared PWM counter
   input  wire logic [`PWMISE_CNT_W-1:0] width,   // Pulse width count
   input  wire logic                     spread,  // Spread the high time
   output logic                          high     // Raw channel level
);

   logic [`PWMISE_CNT_W-3:0] segWidth;  // Share of each quarter
   logic                     extra;     // Quarter takes one more

   // Spread mode splits the cycle into four quarters
   always_comb begin
      segWidth = width[`PWMISE_CNT_W-1:2];
      extra    = (cnt[`PWMISE_CNT_W-1:`PWMISE_CNT_W-2] < width[1:0]);
      if (spread) begin
         high = ({1'b0, cnt[`PWMISE_CNT_W-3:0]} < ({1'b0, segWidth} + {8'h00, extra}));
      end else begin
         high = (cnt < width);
      end
   end

endmodule // pwmise_channel

/* hdl/pwmise_top.sv */
// Four-channel PWM with iteration suppression and a shared interrupt.
// Assumes an APB master on sys_clk; rst is synchronous, active high.
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
`include "pwmise_params.svh"

module pwmise_top (
   input  wire logic                      sys_clk,        // System clock
   input  wire logic                      rst,            // Synchronous reset
   input  wire logic                      psel,           // APB select
   input  wire logic                      penable,        // APB enable
   input  wire logic                      pwrite,         // APB direction
   input  wire logic [`PWMISE_ADDR_W-1:0] paddr,          // APB byte address
   input  wire logic [31:0]               pwdata,         // APB write data
   output logic [31:0]                    prdata,         // APB read data
   output logic                           pready,         // APB ready
   output logic                           pslverr,        // APB error
   output logic [`PWMISE_NUM_CH-1:0]      pwmOut,         // PWM output pins
   output logic                           pwmIrq,         // Interrupt request
   output logic [1:0]                     pwmIrqPriority  // Interrupt priority
);

   pwmise_pkg::pwmise_state_t state;       // Registered state
   pwmise_pkg::pwmise_state_t next_state;  // Next state

   // Register map, byte addresses on a 32-bit word bus:
   //   0x220  channel 0 low-count control, write only
   //   0x228  channel 1 low-count control, write only
   //   0x230  channel 2 low-count control, write only
   //   0x238  channel 3 low-count control, write only
   //   0x200  channel 0 high count, bits 7:0, read/write
   //   0x204  channel 1 high count
   //   0x208  channel 2 high count
   //   0x20C  channel 3 high count
   //   0x240  status: bit 0 interrupt event, bit 1 round done,
   //          bits 10:8 iteration, bits 25:16 count; read clears
   //   0x244  event mask, bits 1:0
   //   0x248  control, bit 0 interrupt only in active iteration
   // Reads of the write-only words return zero without error.
   // Any other address answers with an error and changes nothing.
   //
   // Low-count control byte layout:
   //   7:6  two low bits of the pulse width count
   //   5:4  output suppression code
   //   3    unused, always dropped
   //   2:1  ch 0 interrupt level, ch 1 interrupt suppression,
   //        unused on channels 2 and 3
   //   0    shape: clear for one block, set for spread

   logic [`PWMISE_NUM_CH-1:0] chHigh;      // Raw compare levels
   logic [`PWMISE_NUM_CH-1:0] outActive;   // Iteration passes per channel
   logic                      irqActive;   // Iteration passes for interrupt

   // Bus decode and event helpers
   logic                      access;      // Completing APB access
   logic                      wrAccess;    // Completing write
   logic                      rdAccess;    // Completing read
   logic [`PWMISE_NUM_CH-1:0] hitLsb;      // Low-count register hit
   logic [`PWMISE_NUM_CH-1:0] hitHigh;     // High-count register hit
   logic                      hitStat;     // Status register hit
   logic                      hitMask;     // Mask register hit
   logic                      hitCtrl;     // Control register hit
   logic                      wrap;        // Last count of an iteration
   logic [1:0]                events;      // Events this cycle
   logic [1:0]                clrStat;     // Clear from status read

   // Low-count registers are numbered by word index; the bus
   // carries byte addresses, so the index moves up two bits.
   // Byte address of a low-count register from its index
   function automatic logic [`PWMISE_ADDR_W-1:0] lsbAddr(input int ch);
      logic [9:0] idx;
      idx = `PWMISE_IDX_LSB0;
      unique case (ch)
         1: idx = `PWMISE_IDX_LSB1;
         2: idx = `PWMISE_IDX_LSB2;
         3: idx = `PWMISE_IDX_LSB3;
         default: idx = `PWMISE_IDX_LSB0;
      endcase
      return {idx, 2'b00};
   endfunction

   // Each channel owns a compare stage and an output gate; all
   // of them share the PWM counter and the iteration count.
   // Per-channel compare, suppression and address decode
   genvar gi;
   generate
      for (gi = 0; gi < `PWMISE_NUM_CH; gi++) begin : g_ch
         pwmise_channel u_channel (
            .cnt    (state.cnt),
            .width  (state.width[gi]),
            .spread (state.spread[gi]),
            .high   (chHigh[gi])
         );
         pwmise_iter_gate u_out_gate (
            .code   (state.supp[gi]),
            .iter   (state.iter),
            .active (outActive[gi])
         );
         // Register decode for this channel
         assign hitLsb[gi]  = (paddr == lsbAddr(gi));
         assign hitHigh[gi] = (paddr == (`PWMISE_ADDR_HIGH0 + 12'(4 * gi)));
      end
   endgenerate

   // The interrupt has its own gate on the irqSupp code from channel 1, fed
   // by the same iteration count as the output gates.
   // Interrupt iteration gating
   pwmise_iter_gate u_irq_gate (
      .code   (state.irqSupp),
      .iter   (state.iter),
      .active (irqActive)
   );

   // Decodes compare the full byte address, so an unaligned
   // address never hits a register.
   // Fixed register decode
   assign hitStat = (paddr == `PWMISE_ADDR_STAT);
   assign hitMask = (paddr == `PWMISE_ADDR_MASK);
   assign hitCtrl = (paddr == `PWMISE_ADDR_CTRL);

   // Bus timing: setup cycle, a first access cycle in which the
   // answer is prepared, then a second one with ready high.
   // Exactly one wait state; read data and error stand for that
   // one cycle only and are zero otherwise.
   // APB access completes when the registered ready is seen
   assign access   = psel & penable & state.pready;
   assign wrAccess = access & pwrite;
   assign rdAccess = access & ~pwrite;

   // The PWM counter runs from zero to all ones every clock; the
   // iteration count steps once per wrap, eight make a round.
   // Both restart from zero when reset is released.
   // Iteration ends on the last count
   assign wrap = (state.cnt == {`PWMISE_CNT_W{1'b1}});

   // The event fires on the last count of an iteration, so it
   // lines up with the output gates of the iteration now ending.
   // A status read clears only the bits it returned, so an event
   // arriving while the read is in flight waits for the next one.
   // Event sources for the sticky status bits
   always_comb begin
      events = `PWMISE_RST_EVT;
      events[`PWMISE_F_ST_PWM] = wrap & (state.irqLevel != 2'h0) & irqActive
                                 & (~state.actOnly | outActive[0]);
      // A full round of eight iterations finished
      events[`PWMISE_F_ST_ROUND] = wrap & (state.iter == 3'h7);
      // Clear only the bits that the read handed out
      clrStat = (rdAccess & hitStat) ? state.prdata[1:0] : 2'h0;
   end

   // Next-state logic
   always_comb begin
      next_state = state;

      // Counters never stop; software cannot pause or preload them
      // Counters run every clock
      next_state.cnt = state.cnt + 10'h001;
      if (wrap) begin
         next_state.iter = state.iter + 3'h1;
      end

      // Pins are registered: each follows its compare one clock
      // after the count, the same delay on every channel.
      // Suppressed iterations hold low
      for (int i = 0; i < `PWMISE_NUM_CH; i++) begin
         next_state.pwmOut[i] = chHigh[i] & outActive[i];
      end

      // Ready rises on the second access cycle
      next_state.pready  = psel & penable & ~state.pready;
      next_state.prdata  = `PWMISE_RST_DATA;
      next_state.pslverr = 1'b0;

      // Writes land on the edge that completes the access; unused
      // bits of the written word are dropped.
      // Register writes
      if (wrAccess) begin
         for (int i = 0; i < `PWMISE_NUM_CH; i++) begin
            if (hitLsb[i]) begin
               next_state.width[i][1:0] = pwdata[`PWMISE_F_CNT_HI:`PWMISE_F_CNT_LO];
               next_state.supp[i] = pwdata[`PWMISE_F_SUP_HI:`PWMISE_F_SUP_LO];
               next_state.spread[i] = pwdata[`PWMISE_F_SHAPE];
               // Shared irq fields on channels 0 and 1
               if (i == 0) begin
                  next_state.irqLevel = pwdata[`PWMISE_F_IRQ_HI:`PWMISE_F_IRQ_LO];
               end
               if (i == 1) begin
                  next_state.irqSupp = pwdata[`PWMISE_F_IRQ_HI:`PWMISE_F_IRQ_LO];
               end
               // Channels 2, 3 drop bits 3:1
            end
            if (hitHigh[i]) begin
               // Upper eight count bits
               next_state.width[i][`PWMISE_CNT_W-1:2] = pwdata[7:0];
            end
         end
         if (hitMask) begin
            next_state.mask = pwdata[1:0];
         end
         if (hitCtrl) begin
            next_state.actOnly = pwdata[`PWMISE_F_ACT_ONLY];
         end
      end

      // Read data is prepared one cycle early, while ready is low,
      // so that it stands in the register in the ready cycle.
      // Read data and error answer on the ready cycle
      if (psel & penable & ~state.pready) begin
         if (hitStat) begin
            next_state.prdata[1:0] = state.status;
            next_state.prdata[`PWMISE_F_ST_ITER +: `PWMISE_ITER_W] = state.iter;
            next_state.prdata[`PWMISE_F_ST_CNT +: `PWMISE_CNT_W]   = state.cnt;
         end else if (hitMask) begin
            next_state.prdata[1:0] = state.mask;
         end else if (hitCtrl) begin
            next_state.prdata[`PWMISE_F_ACT_ONLY] = state.actOnly;
         end else if (|hitHigh) begin
            // High counts read back
            for (int i = 0; i < `PWMISE_NUM_CH; i++) begin
               if (hitHigh[i]) begin
                  next_state.prdata[7:0] = state.width[i][`PWMISE_CNT_W-1:2];
               end
            end
         end else if (|hitLsb) begin
            // Write-only registers read as zero
            next_state.prdata = `PWMISE_RST_DATA;
         end else begin
            // Unmapped address
            next_state.pslverr = 1'b1;
         end
      end

      // Sticky status: set wins over read clear
      next_state.status = (state.status & ~clrStat) | events;

      // Line and priority pins come from the next values, so they
      // change on the same edge as their sources.
      // One level request, gated by mask
      next_state.irq    = |(next_state.status & next_state.mask);
      next_state.irqPri = next_state.irqLevel;

      // Reset wins over every other update in the same cycle; pins
      // and interrupt go low, all fields return to reset codes.
      // Synchronous reset
      if (rst) begin
         next_state.cnt      = {`PWMISE_CNT_W{1'b0}};
         next_state.iter     = 3'h0;
         for (int i = 0; i < `PWMISE_NUM_CH; i++) begin
            next_state.width[i] = `PWMISE_RST_WIDTH;
            next_state.supp[i]  = `PWMISE_RST_CODE;
         end
         next_state.spread   = 4'h0;
         next_state.irqLevel = `PWMISE_RST_CODE;
         next_state.irqSupp  = `PWMISE_RST_CODE;
         next_state.actOnly  = 1'b0;
         next_state.status   = `PWMISE_RST_EVT;
         next_state.mask     = `PWMISE_RST_EVT;
         next_state.prdata   = `PWMISE_RST_DATA;
         next_state.pready   = 1'b0;
         next_state.pslverr  = 1'b0;
         next_state.pwmOut   = 4'h0;
         next_state.irq      = 1'b0;
         next_state.irqPri   = 2'h0;
      end
   end

   // One register holds the whole state; reset is folded into
   // the next-state logic above, so this process only copies.
   // Every field updates on every clock edge.
   // State register
   always_ff @(posedge sys_clk) begin
      state <= next_state;
   end

   // Outputs straight from the state register
   assign prdata         = state.prdata;
   assign pready         = state.pready;
   assign pslverr        = state.pslverr;
   assign pwmOut         = state.pwmOut;
   assign pwmIrq         = state.irq;
   assign pwmIrqPriority = state.irqPri;

endmodule // pwmise_top

/* bench/pwmise_top_props.sv */
// Port checker for the PWM extension top.
// Assumes the parameter header on the include path; bound below.
`timescale 1ns/1ns
`include "pwmise_params.svh"

module pwmise_top_props (
   input wire logic                      sys_clk,        // System clock
   input wire logic                      rst,            // Synchronous reset
   input wire logic                      psel,           // APB select
   input wire logic                      penable,        // APB enable
   input wire logic                      pwrite,         // APB direction
   input wire logic [`PWMISE_ADDR_W-1:0] paddr,          // APB byte address
   input wire logic [31:0]               pwdata,         // APB write data
   input wire logic [31:0]               prdata,         // APB read data
   input wire logic                      pready,         // APB ready
   input wire logic                      pslverr,        // APB error
   input wire logic                      pwmIrq,         // Interrupt request
   input wire logic [1:0]                pwmIrqPriority  // Interrupt priority
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   localparam logic [11:0] A_LSB0 = {`PWMISE_IDX_LSB0, 2'b00};
   logic [9:0] phase;   // Mirror of the PWM counter
   logic       wrLsb0;  // Completed write to channel 0 low count
   logic       rdStat;  // Completed status read
   logic       wrMask;  // Completed mask write
   assign wrLsb0 = psel && penable && pready && pwrite && paddr == A_LSB0;
   assign rdStat = psel && penable && pready && !pwrite && paddr == `PWMISE_ADDR_STAT;
   assign wrMask = psel && penable && pready && pwrite && paddr == `PWMISE_ADDR_MASK;
   // Counter mirror, zero in the first cycle after reset
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         phase <= 10'h000;
      end else begin
         phase <= phase + 10'h001;
      end
   end
   a_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_access: assert property (pready |-> psel && penable && $past(penable))
      else $error("pready outside access phase");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero while idle");
   a_err_mapped: assert property (pslverr |-> pready && paddr != A_LSB0
                                  && paddr != `PWMISE_ADDR_STAT && paddr != `PWMISE_ADDR_MASK)
      else $error("pslverr on mapped access");
   a_prio_follow: assert property (wrLsb0 |-> ##2 pwmIrqPriority == $past(pwdata[2:1], 2))
      else $error("priority does not follow field");
   a_irq_rise: assert property ($rose(pwmIrq) |-> phase == 10'h000 || $past(wrMask))
      else $error("interrupt rose off the iteration end");
   a_irq_clear: assert property (rdStat && phase != 10'h3FF && phase != 10'h000 |=> !pwmIrq)
      else $error("status read did not drop interrupt");
endmodule // pwmise_top_props

bind pwmise_top pwmise_top_props u_props (
   .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pwmIrq(pwmIrq), .pwmIrqPriority(pwmIrqPriority));

/* bench/pwmise_servo_load.sv */
// Load model on the PWM pins: counts high cycles and pulses in a window.
// Assumes the same clock as the block; start opens one window.
`timescale 1ns/1ns

module pwmise_servo_load #(
   parameter int WIN = 8192  // Window length, one full iteration round
) (
   input  wire logic        sys_clk,  // System clock
   input  wire logic        start,    // Clears counts, opens window
   input  wire logic [3:0]  pwmOut,   // PWM pins
   output logic [3:0][15:0] highCnt,  // High cycles per pin
   output logic [3:0][7:0]  riseCnt,  // Rising edges per pin
   output logic             busy      // Window open
);
   int         left = 0;     // Cycles left in window
   logic [3:0] prev = 4'h0;  // Last pin sample
   assign busy = (left != 0);
   // Sample the pins every clock; count only inside the window
   always @(posedge sys_clk) begin
      prev <= pwmOut;
      if (start) begin
         left <= WIN;
         highCnt <= '0;
         riseCnt <= '0;
      end else if (left != 0) begin
         left <= left - 1;
         for (int i = 0; i < 4; i++) begin
            highCnt[i] <= highCnt[i] + 16'(pwmOut[i]);
            riseCnt[i] <= riseCnt[i] + 8'(pwmOut[i] & ~prev[i]);
         end
      end
   end
endmodule // pwmise_servo_load

/* bench/test_pwmise_top.sv */
// Self-checking bench for the PWM extension top.
// Assumes design, load model and checker are compiled first.
`timescale 1ns/1ns
`include "pwmise_params.svh"

module test_pwmise_top;
   localparam logic [11:0] A_LSB0 = {`PWMISE_IDX_LSB0, 2'b00};  // Channel 0 low count
   logic        sys_clk = 1'b0;  // Clock
   logic        rst = 1'b1;      // Reset
   logic        psel = 1'b0;     // APB select
   logic        penable = 1'b0;  // APB enable
   logic        pwrite = 1'b0;   // APB direction
   logic [11:0] paddr = 12'h0;   // APB address
   logic [31:0] pwdata = 32'h0;  // APB write data
   logic [31:0] prdata;          // APB read data
   logic        pready;          // APB ready
   logic        pslverr;         // APB error
   logic [3:0]  pwmOut;          // PWM pins
   logic        pwmIrq;          // Interrupt
   logic [1:0]  pwmIrqPriority;  // Interrupt priority
   logic        start = 1'b0;    // Load window start
   logic [3:0][15:0] highCnt;    // Load high counts
   logic [3:0][7:0]  riseCnt;    // Load pulse counts
   logic        busy;            // Load window open
   int          n_errors = 0;    // Mismatches
   int          total_checks = 0; // Comparisons
   always #50 sys_clk = ~sys_clk;
   pwmise_top uut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pwmOut(pwmOut), .pwmIrq(pwmIrq), .pwmIrqPriority(pwmIrqPriority));
   pwmise_servo_load #(.WIN(8192)) load (.sys_clk(sys_clk), .start(start), .pwmOut(pwmOut),
      .highCnt(highCnt), .riseCnt(riseCnt), .busy(busy));
   // One APB transfer, waiting for pready with no bound
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic w(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Active iterations out of eight for a suppression code
   function automatic int act(input logic [1:0] c);
      return (c == 2'h0) ? 8 : 1 << (int'(c) - 1);
   endfunction
   // Write-only read, unmapped access, mask read-back
   task automatic t_regs();
      logic [31:0] r;
      logic        e;
      apb(1'b0, A_LSB0, 32'h0, r, e);
      chk("lsb0 read", 32'h0, r);
      chk("lsb0 err", 32'h0, {31'h0, e});
      apb(1'b0, 12'h300, 32'h0, r, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      w(`PWMISE_ADDR_MASK, 32'h3);
      apb(1'b0, `PWMISE_ADDR_MASK, 32'h0, r, e);
      chk("mask", 32'h3, r);
      w(`PWMISE_ADDR_MASK, 32'h1);
   endtask
   // Every priority code reaches the priority output
   task automatic t_prio();
      for (int c = 0; c < 4; c++) begin
         w(A_LSB0, 32'(c << 1));
         repeat (3) @(posedge sys_clk);
         chk("priority", 32'(c), {30'h0, pwmIrqPriority});
      end
   endtask
   // One full round of eight iterations with the given setup
   task automatic t_wave(input logic [3:0][1:0] sup, input logic [3:0] shp,
                         input logic [1:0] lvl, input logic [1:0] isup, input logic act1);
      logic [31:0] r;
      logic        e;
      logic [1:0]  fld;
      int          nIrq;
      int          exp;
      logic [9:0]  gap;
      w(`PWMISE_ADDR_CTRL, {31'h0, act1});
      for (int i = 0; i < 4; i++) begin
         fld = (i == 0) ? lvl : (i == 1) ? isup : 2'h0;
         w(`PWMISE_ADDR_HIGH0 + 12'(4 * i), 32'h41);
         w(A_LSB0 + 12'(8 * i), {24'h0, 2'b01, sup[i], 1'b0, fld, shp[i]});
      end
      // Park the window start mid-iteration, far from any interrupt edge
      apb(1'b0, `PWMISE_ADDR_STAT, 32'h0, r, e);
      gap = 10'h200 - r[`PWMISE_F_ST_CNT +: `PWMISE_CNT_W];
      repeat (gap) @(posedge sys_clk);
      apb(1'b0, `PWMISE_ADDR_STAT, 32'h0, r, e);
      start <= 1'b1;
      nIrq = 0;
      @(posedge sys_clk);
      start <= 1'b0;
      @(posedge sys_clk);
      while (busy === 1'b1) begin
         if (pwmIrq === 1'b1) begin
            nIrq++;
            apb(1'b0, `PWMISE_ADDR_STAT, 32'h0, r, e);
         end
         @(posedge sys_clk);
      end
      for (int i = 0; i < 4; i++) begin
         chk("high time", 32'(261 * act(sup[i])), 32'(highCnt[i]));
         chk("pulses", 32'(act(sup[i]) * (shp[i] ? 4 : 1)), 32'(riseCnt[i]));
      end
      exp = (lvl == 2'h0) ? 0 : act(isup);
      if (act1 && act(sup[0]) < exp) exp = act(sup[0]);
      chk("irq events", 32'(exp), 32'(nIrq));
   endtask
   // Verdict and end of run
   task automatic results();
      if (n_errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs();
      t_prio();
      t_wave({2'h3, 2'h2, 2'h1, 2'h0}, 4'b1010, 2'h1, 2'h1, 1'b0);
      t_wave({2'h0, 2'h1, 2'h2, 2'h3}, 4'b0101, 2'h3, 2'h0, 1'b0);
      t_wave({2'h0, 2'h1, 2'h2, 2'h2}, 4'b0011, 2'h2, 2'h3, 1'b1);
      t_wave({2'h1, 2'h1, 2'h1, 2'h1}, 4'b1111, 2'h0, 2'h0, 1'b0);
      t_wave({2'h2, 2'h3, 2'h0, 2'h1}, 4'b0110, 2'h2, 2'h2, 1'b1);
      results();
   end
   // Watchdog against a hung run
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_errors++;
      results();
   end
endmodule // test_pwmise_top
